/* File: hw/msf_map.vh */
// Register map and constants of the motor stop and frequency limit block
`ifndef MSF_MAP_VH
`define MSF_MAP_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MSF_OFF_CTRL      12'h000
`define MSF_OFF_STOPMODE  12'h004
`define MSF_OFF_BLOCKT    12'h008
`define MSF_OFF_BRAKET    12'h00c
`define MSF_OFF_BRAKELVL  12'h010
`define MSF_OFF_BRAKEFRQ  12'h014
`define MSF_OFF_STARTFRQ  12'h018
`define MSF_OFF_MAXFRQ    12'h01c
`define MSF_OFF_LIMEN     12'h020
`define MSF_OFF_LIMLO     12'h024
`define MSF_OFF_LIMHI     12'h028
`define MSF_OFF_DWELL     12'h02c
`define MSF_OFF_RATIO     12'h030
`define MSF_OFF_STATUS    12'h034
`define MSF_OFF_OUTFRQ    12'h038
// ----------------------------------------------------------------
// Stop methods
// ----------------------------------------------------------------
`define MSF_STOP_DEC      3'h0
`define MSF_STOP_DCBRAKE  3'h1
`define MSF_STOP_COAST    3'h2
`define MSF_STOP_PWRBRAKE 3'h4
// ----------------------------------------------------------------
// Reset values and limits (frequency in 0.01 Hz, time in 10 ms ticks)
// ----------------------------------------------------------------
`define MSF_RST_BLOCKT    16'h000a
`define MSF_RST_BRAKET    16'h0064
`define MSF_RST_BRAKELVL  16'h0032
`define MSF_RST_BRAKEFRQ  16'h01f4
`define MSF_RST_STARTFRQ  16'h0032
`define MSF_RST_MAXFRQ    16'h1770
`define MSF_RST_LIMLO     16'h0032
`define MSF_RST_RATIO     16'h00c8
`define MSF_MAX_TIME      16'h1770
`define MSF_MIN_STARTFRQ  16'h0001
`define MSF_MAX_STARTFRQ  16'h03e8
`define MSF_MIN_MAXFRQ    16'h0fa0
`define MSF_MAX_MAXFRQ    16'h9c40
`define MSF_MAX_BRAKEFRQ  16'h1770
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MSF_TICK_NS       10000000
`define MSF_CLK_NS        40
`define MSF_TICK_CYCLES   (`MSF_TICK_NS / `MSF_CLK_NS)
`endif

/* File: hw/msf_motor_stop.v */
// Stop method sequencer and frequency clamp with an APB register slave
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "msf_map.vh"
module msf_motor_stop #(
  parameter TICK_CYCLES = `MSF_TICK_CYCLES,
  parameter STEP        = 16'h0001
) (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        busOverVolt,
  output reg  [15:0] outFreq,
  output reg         outEnable,
  output reg         dcInject,
  output reg  [15:0] dcLevel,
  output reg         stopped
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RUN  = 3'h1;
  localparam [2:0] ST_DEC  = 3'h2;
  localparam [2:0] ST_BLK  = 3'h3;
  localparam [2:0] ST_DCB  = 3'h4;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  // Start frequency clamp comes last: a lower limit under it still gives zero
  function [15:0] clampReq;
    input [15:0] req;
    input [15:0] startF;
    input [15:0] maxF;
    input        limEn;
    input [15:0] lo;
    input [15:0] hi;
    reg   [15:0] v;
    begin
      v = (req > maxF) ? maxF : req;
      if (limEn)
      begin
        if (v < lo)
          v = lo;
        if (v > hi)
          v = hi;
      end
      if (v < startF)
        v = 16'h0000;
      clampReq = v;
    end
  endfunction

  function [15:0] capVal;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      capVal = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg        runCmd_reg;
  reg        stallEn_reg;
  reg [15:0] freqReq_reg;
  reg [2:0]  stopMode_reg;
  reg [15:0] blockT_reg;
  reg [15:0] brakeT_reg;
  reg [15:0] brakeLvl_reg;
  reg [15:0] brakeFrq_reg;
  reg [15:0] startFrq_reg;
  reg [15:0] maxFrq_reg;
  reg        limEn_reg;
  reg [15:0] limLo_reg;
  reg [15:0] limHi_reg;
  reg [15:0] dwell_reg;
  reg [15:0] ratio_reg;
  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [31:0] tickCnt_reg;
  reg [15:0] timeCnt_reg;
  reg        stallAct_reg;
  reg        pwrAct_reg;

  wire        wrEn   = psel & penable & pwrite;
  wire [15:0] wd     = pwdata[15:0];
  wire [15:0] target = clampReq(freqReq_reg, startFrq_reg, maxFrq_reg, limEn_reg,
                                limLo_reg, limHi_reg);
  wire        tick   = (tickCnt_reg == TICK_LAST);
  wire        decel  = (state_reg == ST_DEC) || (state_reg == ST_RUN && outFreq > target);
  wire        pwrSel = (stopMode_reg == `MSF_STOP_PWRBRAKE);
  wire        pwrHold = pwrSel & decel & busOverVolt;
  // No dwell stage: a dwell below the braking frequency never delays braking
  wire [15:0] dcThr  = (dwell_reg != 16'h0000 && dwell_reg < brakeFrq_reg) ?
                       brakeFrq_reg : brakeFrq_reg;

  // Zero wait state slave; unmapped offsets are ignored without error
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // ----------------------------------------------------------------
  // APB register writes
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      runCmd_reg   <= 1'b0;
      stallEn_reg  <= 1'b0;
      freqReq_reg  <= 16'h0000;
      stopMode_reg <= `MSF_STOP_DEC;
      blockT_reg   <= `MSF_RST_BLOCKT;
      brakeT_reg   <= `MSF_RST_BRAKET;
      brakeLvl_reg <= `MSF_RST_BRAKELVL;
      brakeFrq_reg <= `MSF_RST_BRAKEFRQ;
      startFrq_reg <= `MSF_RST_STARTFRQ;
      maxFrq_reg   <= `MSF_RST_MAXFRQ;
      limEn_reg    <= 1'b0;
      limLo_reg    <= `MSF_RST_LIMLO;
      limHi_reg    <= `MSF_RST_MAXFRQ;
      dwell_reg    <= 16'h0000;
      ratio_reg    <= `MSF_RST_RATIO;
    end
    else if (wrEn)
    begin
      case (paddr)
        `MSF_OFF_CTRL:
        begin
          runCmd_reg  <= pwdata[0];
          stallEn_reg <= pwdata[1];
          freqReq_reg <= pwdata[31:16];
        end
        `MSF_OFF_STOPMODE: stopMode_reg <= pwdata[2:0];
        `MSF_OFF_BLOCKT:   blockT_reg   <= capVal(wd, 16'h0000, `MSF_MAX_TIME);
        `MSF_OFF_BRAKET:   brakeT_reg   <= capVal(wd, 16'h0000, `MSF_MAX_TIME);
        `MSF_OFF_BRAKELVL: brakeLvl_reg <= capVal(wd, 16'h0000, ratio_reg);
        `MSF_OFF_BRAKEFRQ: brakeFrq_reg <= capVal(wd, 16'h0000, `MSF_MAX_BRAKEFRQ);
        `MSF_OFF_STARTFRQ: startFrq_reg <= capVal(wd, `MSF_MIN_STARTFRQ, `MSF_MAX_STARTFRQ);
        `MSF_OFF_MAXFRQ:
        begin
          // Lowering the maximum pulls the upper limit down with it
          maxFrq_reg <= capVal(wd, `MSF_MIN_MAXFRQ, `MSF_MAX_MAXFRQ);
          if (limHi_reg > capVal(wd, `MSF_MIN_MAXFRQ, `MSF_MAX_MAXFRQ))
            limHi_reg <= capVal(wd, `MSF_MIN_MAXFRQ, `MSF_MAX_MAXFRQ);
        end
        `MSF_OFF_LIMEN:    limEn_reg    <= pwdata[0];
        `MSF_OFF_LIMLO:    limLo_reg    <= capVal(wd, 16'h0000, maxFrq_reg);
        `MSF_OFF_LIMHI:    limHi_reg    <= capVal(wd, limLo_reg, maxFrq_reg);
        `MSF_OFF_DWELL:    dwell_reg    <= capVal(wd, 16'h0000, maxFrq_reg);
        `MSF_OFF_RATIO:
        begin
          ratio_reg <= wd;
          if (brakeLvl_reg > wd)
            brakeLvl_reg <= wd;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB read data
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (reset)
      prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite)
    begin
      case (paddr)
        `MSF_OFF_CTRL:     prdata <= {freqReq_reg, 14'h0000, stallEn_reg, runCmd_reg};
        `MSF_OFF_STOPMODE: prdata <= {29'h00000000, stopMode_reg};
        `MSF_OFF_BLOCKT:   prdata <= {16'h0000, blockT_reg};
        `MSF_OFF_BRAKET:   prdata <= {16'h0000, brakeT_reg};
        `MSF_OFF_BRAKELVL: prdata <= {16'h0000, brakeLvl_reg};
        `MSF_OFF_BRAKEFRQ: prdata <= {16'h0000, brakeFrq_reg};
        `MSF_OFF_STARTFRQ: prdata <= {16'h0000, startFrq_reg};
        `MSF_OFF_MAXFRQ:   prdata <= {16'h0000, maxFrq_reg};
        `MSF_OFF_LIMEN:    prdata <= {31'h00000000, limEn_reg};
        `MSF_OFF_LIMLO:    prdata <= {16'h0000, limLo_reg};
        `MSF_OFF_LIMHI:    prdata <= {16'h0000, limHi_reg};
        `MSF_OFF_DWELL:    prdata <= {16'h0000, dwell_reg};
        `MSF_OFF_RATIO:    prdata <= {16'h0000, ratio_reg};
        `MSF_OFF_STATUS:   prdata <= {24'h000000, pwrAct_reg, stallAct_reg, dcInject,
                                      outEnable, stopped, state_reg};
        `MSF_OFF_OUTFRQ:   prdata <= {16'h0000, outFreq};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Stop sequencer
  // ----------------------------------------------------------------
  // Intervals end on their last tick, so each nonzero count lasts exactly its count of ticks; a zero count lasts one clock
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (runCmd_reg && target != 16'h0000)
          state_next = ST_RUN;
      ST_RUN:
        if (!runCmd_reg)
        begin
          if (stopMode_reg == `MSF_STOP_COAST)
            state_next = ST_IDLE;
          else
            state_next = ST_DEC;
        end
      ST_DEC:
        if (runCmd_reg)
          state_next = ST_RUN;
        else if (stopMode_reg == `MSF_STOP_DCBRAKE && outFreq <= dcThr)
          state_next = ST_BLK;
        else if (outFreq == 16'h0000)
          state_next = ST_IDLE;
      ST_BLK:
        if (tick && timeCnt_reg + 16'h0001 >= blockT_reg)
          state_next = ST_DCB;
        else if (blockT_reg == 16'h0000)
          state_next = ST_DCB;
      ST_DCB:
        if (brakeT_reg == 16'h0000 || (tick && timeCnt_reg + 16'h0001 >= brakeT_reg))
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_reg    <= ST_IDLE;
      tickCnt_reg  <= 32'h00000000;
      timeCnt_reg  <= 16'h0000;
      outFreq      <= 16'h0000;
      outEnable    <= 1'b0;
      dcInject     <= 1'b0;
      dcLevel      <= 16'h0000;
      stopped      <= 1'b1;
      stallAct_reg <= 1'b0;
      pwrAct_reg   <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      tickCnt_reg  <= (tick || state_next != state_reg) ? 32'h00000000 : tickCnt_reg + 32'h1;
      if (state_next != state_reg)
        timeCnt_reg <= 16'h0000;
      else if (tick)
        timeCnt_reg <= timeCnt_reg + 16'h0001;
      pwrAct_reg   <= pwrHold;
      stallAct_reg <= stallEn_reg & decel & busOverVolt & ~pwrSel;
      outEnable    <= (state_next == ST_RUN) || (state_next == ST_DEC);
      dcInject     <= (state_next == ST_DCB);
      dcLevel      <= (state_next == ST_DCB) ? brakeLvl_reg : 16'h0000;
      stopped      <= (state_next == ST_IDLE);
      if (state_next == ST_RUN)
      begin
        if (outFreq < target)
          outFreq <= (target - outFreq < STEP) ? target : outFreq + STEP;
        else if (outFreq > target && !pwrHold)
          outFreq <= (outFreq - target < STEP) ? target : outFreq - STEP;
      end
      else if (state_next == ST_DEC)
      begin
        if (pwrHold)
          outFreq <= outFreq;
        else
          outFreq <= (outFreq < STEP) ? 16'h0000 : outFreq - STEP;
      end
      else
        outFreq <= 16'h0000;
    end
  end
endmodule

/* File: verif/msf_motor_model.sv */
// Behavioural motor and load whose DC bus rises while the drive holds or slows it
`timescale 1ns/1ns
module msf_motor_model (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        regenOn,
  input  wire logic [15:0] outFreq,
  input  wire logic        outEnable,
  input  wire logic        dcInject,
  output wire logic        busOverVolt
);
  logic [15:0] speedReg;
  always @(posedge clk_sys)
  begin
    if (reset || dcInject)
      speedReg <= 16'h0000;
    else if (outEnable)
      speedReg <= outFreq;
    else if (speedReg != 16'h0000)
      speedReg <= speedReg - 16'h0001;
  end
  // Load spinning as fast as the drive or faster pushes energy back
  assign busOverVolt = regenOn && outEnable && (outFreq <= speedReg);
endmodule

/* File: verif/msf_motor_stop_properties.sv */
// Concurrent checks of the motor stop and frequency limit block
`timescale 1ns/1ns
`include "msf_map.vh"
module msf_motor_stop_properties #(
  parameter TICK_CYCLES = 4
) (
  input logic        clk_sys,
  input logic        reset,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        busOverVolt,
  input logic [15:0] outFreq,
  input logic        outEnable,
  input logic        dcInject,
  input logic [15:0] dcLevel,
  input logic        stopped
);
  logic [15:0] cfgReg [0:15];
  logic [31:0] blkCnt;
  logic [31:0] injCnt;
  wire         wrEn   = psel && penable && pwrite;
  wire  [2:0]  mode   = cfgReg[1][2:0];
  wire         run    = cfgReg[0][0];
  wire  [31:0] blkLen = cfgReg[2] * TICK_CYCLES;
  wire  [31:0] injLen = cfgReg[3] * TICK_CYCLES;
  wire  [15:0] lvlExp = (cfgReg[4] < cfgReg[12]) ? cfgReg[4] : cfgReg[12];
  wire  [15:0] maxExp = (cfgReg[7] < `MSF_MIN_MAXFRQ) ? `MSF_MIN_MAXFRQ : cfgReg[7];
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int i = 0; i < 16; i++)
        cfgReg[i] <= 16'h0000;
      cfgReg[2]  <= `MSF_RST_BLOCKT;
      cfgReg[3]  <= `MSF_RST_BRAKET;
      cfgReg[4]  <= `MSF_RST_BRAKELVL;
      cfgReg[7]  <= `MSF_RST_MAXFRQ;
      cfgReg[12] <= `MSF_RST_RATIO;
      blkCnt     <= 32'h0;
      injCnt     <= 32'h0;
    end
    else
    begin
      if (wrEn && paddr[11:6] == 6'h00)
        cfgReg[paddr[5:2]] <= pwdata[15:0];
      blkCnt <= (!outEnable && !dcInject && !stopped) ? blkCnt + 1 : 32'h0;
      injCnt <= dcInject ? injCnt + 1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_coastStop;
    wrEn && paddr == 12'h000 && !pwdata[0] && mode == 3'h2;
  endsequence
  sequence s_pwrHold;
    (mode == 3'h4 && !run && outEnable && busOverVolt)[*4];
  endsequence
  a_level_idle: assert property (!dcInject |-> dcLevel == 16'h0000)
    else $error("level while idle");
  a_level_capped: assert property (dcInject |-> dcLevel == lvlExp)
    else $error("level wrong");
  a_block_time: assert property ($rose(dcInject) |-> blkCnt + 1 >= blkLen && blkCnt <= blkLen + 2)
    else $error("block time wrong");
  a_inject_time: assert property ($fell(dcInject) |-> injCnt + 1 >= injLen && injCnt <= injLen + 2)
    else $error("inject time wrong");
  a_inject_then_stop: assert property ($fell(dcInject) |-> ##[0:2] stopped)
    else $error("no stop after inject");
  a_stopped_quiet: assert property (stopped && !run |-> !outEnable && !dcInject)
    else $error("output while stopped");
  a_coast_off: assert property (s_coastStop |-> ##[1:3] !outEnable)
    else $error("coast output on");
  a_freq_capped: assert property (outFreq <= maxExp)
    else $error("freq above max");
  a_power_hold: assert property (s_pwrHold |-> $stable(outFreq))
    else $error("no hold on high bus");
  a_dec_no_inject: assert property (mode != 3'h1 |-> !dcInject)
    else $error("inject in other mode");
endmodule
bind msf_motor_stop msf_motor_stop_properties #(.TICK_CYCLES(TICK_CYCLES)) uProps (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busOverVolt(busOverVolt), .outFreq(outFreq), .outEnable(outEnable),
  .dcInject(dcInject), .dcLevel(dcLevel), .stopped(stopped));

/* File: verif/test_msf_motor_stop.sv */
// Self-checking bench for the motor stop and frequency limit block
`timescale 1ns/1ns
module test_msf_motor_stop;
  logic        clk_sys = 1'b0;
  logic        reset   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic        regenOn = 1'b0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         busOverVolt;
  wire  [15:0] outFreq;
  wire  [15:0] dcLevel;
  wire         outEnable;
  wire         dcInject;
  wire         stopped;
  logic [31:0] rd;
  logic [15:0] hold;
  int          badCount = 0;
  int          totalChecks = 0;
  int          n;
  logic [44:0] tbl [14] = '{45'h0008_0000_000a, 45'h000c_0000_0064, 45'h0010_0000_0032,
    45'h0014_0000_01f4, 45'h0018_0000_0032, 45'h001c_0000_1770, 45'h0020_0000_0000,
    45'h0028_0000_1770, 45'h003c_0000_0000, 45'h1018_0000_0001, 45'h1018_0400_03e8,
    45'h1018_0032_0032, 45'h1010_012c_00c8, 45'h101c_0010_0fa0};
  always #20 clk_sys = ~clk_sys;
  msf_motor_stop #(.TICK_CYCLES(4)) DUT (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busOverVolt(busOverVolt), .outFreq(outFreq), .outEnable(outEnable),
    .dcInject(dcInject), .dcLevel(dcLevel), .stopped(stopped));
  msf_motor_model MOTOR (
    .clk_sys(clk_sys), .reset(reset), .regenOn(regenOn), .outFreq(outFreq),
    .outEnable(outEnable), .dcInject(dcInject), .busOverVolt(busOverVolt));
  task automatic reportAndStop;
    if (badCount == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; read data is taken at the completing edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    for (n = 1; pready !== 1'b1 && n < 50; n++)
      @(posedge clk_sys);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    check("ready", {31'h0, pready}, 32'h1);
    check("error", {31'h0, pslverr}, 32'h0);
    if (n >= 50)
      reportAndStop();
    @(posedge clk_sys);
  endtask
  // Bounded wait: 0 stopped, 1 injecting, 2 output frequency equals v
  task automatic waitFor(input int sel, input logic [15:0] v);
    for (n = 0; n < 9000; n++)
    begin
      @(posedge clk_sys);
      if (sel == 0 ? stopped === 1'b1 : sel == 1 ? dcInject === 1'b1 : outFreq === v)
        break;
    end
    check("wait", {31'h0, n < 9000}, 32'h1);
    if (n >= 9000)
      reportAndStop();
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    foreach (tbl[i])
    begin
      if (tbl[i][44])
        xfer(1'b1, tbl[i][43:32], {16'h0000, tbl[i][31:16]});
      xfer(1'b0, tbl[i][43:32], 32'h0);
      check("register", rd, {16'h0000, tbl[i][15:0]});
    end
    xfer(1'b1, 12'h000, 32'h0031_0001);
    repeat (20) @(posedge clk_sys);
    check("below start", outFreq, 16'h0000);
    xfer(1'b1, 12'h000, 32'h2000_0001);
    waitFor(2, 16'h0fa0);
    repeat (20) @(posedge clk_sys);
    check("max cap", outFreq, 16'h0fa0);
    xfer(1'b1, 12'h024, 32'h0000_0100);
    xfer(1'b1, 12'h028, 32'h0000_0300);
    xfer(1'b1, 12'h000, 32'h0400_0001);
    waitFor(2, 16'h0400);
    xfer(1'b1, 12'h020, 32'h0000_0001);
    waitFor(2, 16'h0300);
    xfer(1'b1, 12'h000, 32'h0080_0001);
    waitFor(2, 16'h0100);
    xfer(1'b1, 12'h020, 32'h0000_0000);
    waitFor(2, 16'h0080);
    xfer(1'b1, 12'h000, 32'h0000_0000);
    waitFor(0, 16'h0000);
    @(posedge clk_sys);
    check("decel stop", {outFreq, dcInject, outEnable}, 18'h0);
    xfer(1'b1, 12'h004, 32'h0000_0002);
    xfer(1'b1, 12'h000, 32'h0100_0001);
    waitFor(2, 16'h0100);
    xfer(1'b1, 12'h000, 32'h0000_0000);
    @(posedge clk_sys);
    check("coast off", outEnable, 1'b0);
    waitFor(0, 16'h0000);
    xfer(1'b1, 12'h004, 32'h0000_0001);
    xfer(1'b1, 12'h02c, 32'h0000_0100);
    xfer(1'b1, 12'h000, 32'h0300_0001);
    waitFor(2, 16'h0300);
    xfer(1'b1, 12'h000, 32'h0000_0000);
    for (n = 0; outEnable === 1'b1 && n < 2000; n++)
    begin
      hold = outFreq;
      @(posedge clk_sys);
    end
    check("brake freq", hold, 16'h01f4);
    waitFor(1, 16'h0000);
    check("block time", n + 1, 40);
    check("brake level", dcLevel, 16'h00c8);
    for (n = 0; dcInject === 1'b1 && n < 500; n++)
      @(posedge clk_sys);
    check("inject time", {31'h0, n >= 398 && n <= 402}, 32'h1);
    repeat (5) @(posedge clk_sys);
    check("after inject", {stopped, outEnable, dcInject}, 3'b100);
    xfer(1'b1, 12'h004, 32'h0000_0004);
    xfer(1'b1, 12'h000, 32'h0300_0003);
    waitFor(2, 16'h0300);
    regenOn <= 1'b1;
    xfer(1'b1, 12'h000, 32'h0000_0002);
    repeat (10) @(posedge clk_sys);
    hold = outFreq;
    repeat (10) @(posedge clk_sys);
    check("power hold", outFreq, hold);
    xfer(1'b0, 12'h034, 32'h0);
    check("brake over stall", rd[7:6], 2'b10);
    regenOn <= 1'b0;
    waitFor(0, 16'h0000);
    reportAndStop();
  end
endmodule
